// file: rpsc_core.sv
`timescale 1ns/1ps
`include "rpsc_cfg.svh"
module rpsc_core
	import rpsc_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire logic         rst_b,
	input  wire logic         sys_rst_b,
	input  wire logic         key_wr,
	input  wire logic [7:0]   key_data,
	input  wire logic         init_wr,
	input  wire logic         init_val,
	input  wire logic         psc_wr,
	input  wire logic [6:0]   psc_async,
	input  wire logic [12:0]  psc_sync,
	input  wire logic         cal_wr,
	input  wire rpsc_word_t   cal_time,
	input  wire rpsc_word_t   cal_date,
	input  wire logic         rsf_clr,
	input  wire logic         refclk_wr,
	input  wire logic         refclk_val,
	input  wire logic         clksrc_wr,
	input  wire logic [1:0]   clksrc_val,
	input  wire logic         ien_wr,
	input  wire rpsc_flags_t  ien_val,
	input  wire logic         deinit,
	input  wire logic         tamp_cfg_wr,
	input  wire logic [7:0]   tamp_cfg_val,
	input  wire rpsc_flags_t  evt_in,
	input  wire rpsc_flags_t  flag_clr,
	input  wire logic         bkp_wr,
	input  wire logic [4:0]   bkp_wr_idx,
	input  wire rpsc_word_t   bkp_wdata,
	input  wire logic [4:0]   bkp_rd_idx,
	output rpsc_word_t        bkp_rdata,
	output rpsc_word_t        time_shadow_reg,
	output rpsc_word_t        date_shadow_reg,
	output logic              shadow_synced_flag,
	output logic              init_active,
	output logic              wr_unlocked,
	output logic              refclk_det_en,
	output logic [1:0]        kernel_clock_sel,
	output logic [6:0]        psc_async_out,
	output logic [12:0]       psc_sync_out,
	output rpsc_flags_t       ien_out,
	output rpsc_flags_t       evt_flags,
	output logic [7:0]        tamper_altfunc_cfg,
	output logic              alarm_irq_line17,
	output logic              wakeup_irq_channel,
	output logic              tamper_stamp_irq
);
	// ***************************************************
	// System reset synchroniser and protection.
	// ***************************************************
	logic [1:0]  srst_q;
	logic [1:0]  key_st_q;
	logic        unlock_q;
	wire         sys_rst    = !srst_q[1];
	wire         key_good1  = key_wr && (key_data == `RPSC_KEY_FIRST);
	wire         key_good2  = key_wr && (key_data == `RPSC_KEY_SECOND) && key_st_q[0];
	wire         soft_clr   = deinit && unlock_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			srst_q <= 2'h0;
		end else begin
			srst_q <= {srst_q[0], sys_rst_b};
		end
	end

	// Only rst_b touches the lock, so a system reset leaves it as it was.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			key_st_q <= 2'h0;
			unlock_q <= 1'b0;
		end else if (key_wr) begin
			key_st_q <= {1'b0, key_good1 && !unlock_q};
			unlock_q <= key_good2;
		end
	end

	// ***************************************************
	// Initialization mode and calendar run state.
	// ***************************************************
	rpsc_cal_e  st_q;
	rpsc_cal_e  st_d;
	logic [2:0] rst_cnt_q;
	wire        init_go   = init_wr && unlock_q;
	wire        in_init   = (st_q == RPSC_ST_INIT);

	always_comb begin
		st_d = st_q;
		case (st_q)
			RPSC_ST_RUN: begin
				if (init_go && init_val) st_d = RPSC_ST_INIT;
			end
			RPSC_ST_INIT: begin
				if (init_go && !init_val) st_d = RPSC_ST_RESTART;
			end
			RPSC_ST_RESTART: begin
				if (init_go && init_val) st_d = RPSC_ST_INIT;
				else if (rst_cnt_q == `RPSC_RESTART_CYC - 3'h1) st_d = RPSC_ST_RUN;
			end
			default: st_d = RPSC_ST_RUN;
		endcase
		if (soft_clr) st_d = RPSC_ST_RUN;
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q      <= RPSC_ST_RUN;
			rst_cnt_q <= 3'h0;
		end else begin
			st_q      <= st_d;
			rst_cnt_q <= (st_q == RPSC_ST_RESTART) ? rst_cnt_q + 3'h1 : 3'h0;
		end
	end

	// ***************************************************
	// Prescaler, calendar and shadow copy.
	// ***************************************************
	rpsc_tick_if tk ();
	logic [6:0]  async_q;
	logic [12:0] sync_q;
	rpsc_word_t  time_q;
	rpsc_word_t  date_q;
	logic        rsf_q;
	wire         cal_run  = (st_q == RPSC_ST_RUN);
	wire         psc_load = psc_wr && unlock_q && in_init;
	wire         cal_load = cal_wr && unlock_q && in_init;
	wire         day_wrap = (time_q == `RPSC_DAY_LAST);
	// The shadow copy waits for a running calendar so a half-loaded value
	// is never presented as synchronised.
	wire         copy_now = cal_run && !rsf_q;

	assign tk.run       = cal_run;
	assign tk.async_div = async_q;
	assign tk.sync_div  = sync_q;

	rpsc_presc u_presc (
		.ref_clk (ref_clk),
		.rst_b   (rst_b),
		.tk      (tk)
	);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			async_q <= `RPSC_ASYNC_RST;
			sync_q  <= `RPSC_SYNC_RST;
		end else if (soft_clr) begin
			async_q <= `RPSC_ASYNC_RST;
			sync_q  <= `RPSC_SYNC_RST;
		end else if (psc_load) begin
			async_q <= psc_async;
			sync_q  <= psc_sync;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			time_q <= 32'h0000_0000;
			date_q <= 32'h0000_0000;
		end else if (soft_clr) begin
			time_q <= 32'h0000_0000;
			date_q <= 32'h0000_0000;
		end else if (cal_load) begin
			time_q <= cal_time;
			date_q <= cal_date;
		end else if (cal_run && tk.sec_tick) begin
			time_q <= day_wrap ? 32'h0000_0000 : time_q + 32'h0000_0001;
			date_q <= day_wrap ? date_q + 32'h0000_0001 : date_q;
		end
	end

	// A copy in the cycle of a clear wins, so no synchronisation is lost.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rsf_q           <= 1'b0;
			time_shadow_reg <= 32'h0000_0000;
			date_shadow_reg <= 32'h0000_0000;
		end else begin
			if (copy_now) begin
				time_shadow_reg <= time_q;
				date_shadow_reg <= date_q;
			end
			if (copy_now) rsf_q <= 1'b1;
			else if ((rsf_clr && unlock_q) || soft_clr || cal_load || in_init) rsf_q <= 1'b0;
		end
	end

	// ***************************************************
	// Configuration registers and backup storage.
	// ***************************************************
	logic       refclk_q;
	logic [1:0] clksrc_q;
	logic [7:0] tamp_q;
	rpsc_word_t bkp_q [`RPSC_BKP_NUM];
	wire        bkp_hit = bkp_wr && (bkp_wr_idx < 5'(`RPSC_BKP_NUM));

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			refclk_q <= 1'b0;
			clksrc_q <= `RPSC_CLKSRC_RST;
			tamp_q   <= 8'h00;
		end else begin
			if (soft_clr) refclk_q <= 1'b0;
			else if (refclk_wr && unlock_q) refclk_q <= refclk_val;
			if (clksrc_wr && unlock_q) clksrc_q <= clksrc_val;
			if (soft_clr) tamp_q <= 8'h00;
			else if (tamp_cfg_wr) tamp_q <= tamp_cfg_val;
		end
	end

	// Backup words take no part in any reset, soft default included.
	always_ff @(posedge ref_clk) begin
		if (bkp_hit) bkp_q[bkp_wr_idx] <= bkp_wdata;
		bkp_rdata <= (bkp_rd_idx < 5'(`RPSC_BKP_NUM)) ? bkp_q[bkp_rd_idx] : 32'h0000_0000;
	end

	// ***************************************************
	// Event flags, enables and router lines.
	// ***************************************************
	rpsc_flags_t flag_q;
	rpsc_flags_t ien_q;
	logic        irq17_q;
	logic        irq22_q;
	logic        irq21_q;
	wire rpsc_flags_t pend = flag_q & ien_q;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= 5'h00;
			ien_q  <= 5'h00;
		end else if (sys_rst || soft_clr) begin
			flag_q <= 5'h00;
			ien_q  <= 5'h00;
		end else begin
			// Flag clears sit in the always-writable status field; set wins.
			flag_q <= evt_in | (flag_q & ~flag_clr);
			if (ien_wr && unlock_q) ien_q <= ien_val;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq17_q <= 1'b0;
			irq22_q <= 1'b0;
			irq21_q <= 1'b0;
		end else begin
			irq17_q <= pend[`RPSC_F_ALRA] || pend[`RPSC_F_ALRB];
			irq22_q <= pend[`RPSC_F_WUT];
			irq21_q <= pend[`RPSC_F_TAMP] || pend[`RPSC_F_TS];
		end
	end

	assign alarm_irq_line17   = irq17_q;
	assign wakeup_irq_channel = irq22_q;
	assign tamper_stamp_irq   = irq21_q;
	assign shadow_synced_flag = rsf_q;
	assign init_active        = in_init;
	assign wr_unlocked        = unlock_q;
	assign refclk_det_en      = refclk_q;
	assign kernel_clock_sel   = clksrc_q;
	assign psc_async_out      = async_q;
	assign psc_sync_out       = sync_q;
	assign ien_out            = ien_q;
	assign evt_flags          = flag_q;
	assign tamper_altfunc_cfg = tamp_q;
endmodule

// file: rpsc_cfg.svh
`ifndef RPSC_CFG_SVH
`define RPSC_CFG_SVH

// Unlock key sequence; values are arbitrary.
`define RPSC_KEY_FIRST   8'hA5
`define RPSC_KEY_SECOND  8'h5A
// Prescaler reset values.
`define RPSC_ASYNC_RST   7'h7F
`define RPSC_SYNC_RST    13'h00FF
// Seconds in a day, minus one.
`define RPSC_DAY_LAST    32'h0001517F
// Kernel cycles between leaving init mode and counting.
`define RPSC_RESTART_CYC 3'h4
`define RPSC_CLKSRC_RST  2'h0
// Event flag positions in the flag vectors.
`define RPSC_F_ALRA      0
`define RPSC_F_ALRB      1
`define RPSC_F_WUT       2
`define RPSC_F_TAMP      3
`define RPSC_F_TS        4
`define RPSC_BKP_NUM     20
`endif

// file: rpsc_pkg.sv
package rpsc_pkg;
	typedef enum logic [2:0] {
		RPSC_ST_RUN     = 3'h1,
		RPSC_ST_INIT    = 3'h2,
		RPSC_ST_RESTART = 3'h4
	} rpsc_cal_e;
	typedef logic [31:0] rpsc_word_t;
	typedef logic [4:0]  rpsc_flags_t;
endpackage

// file: rpsc_tick_if.sv
`timescale 1ns/1ps
interface rpsc_tick_if;
	logic        run;
	logic [6:0]  async_div;
	logic [12:0] sync_div;
	logic        sec_tick;
	modport core  (output run, output async_div, output sync_div, input sec_tick);
	modport presc (input run, input async_div, input sync_div, output sec_tick);
endinterface

// file: rpsc_presc.sv
`timescale 1ns/1ps
module rpsc_presc
	import rpsc_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	rpsc_tick_if.presc tk
);
	logic [6:0]  async_q;
	logic [12:0] sync_q;
	logic        tick_q;
	wire         async_wrap = (async_q == tk.async_div);
	wire         sync_wrap  = (sync_q == tk.sync_div);

	// ***************************************************
	// Two-stage divider down to the one-second tick.
	// ***************************************************
	// A stopped calendar also restarts both stages from zero, so the first
	// second after a load is a full second.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			async_q <= 7'h00;
			sync_q  <= 13'h0000;
			tick_q  <= 1'b0;
		end else if (!tk.run) begin
			async_q <= 7'h00;
			sync_q  <= 13'h0000;
			tick_q  <= 1'b0;
		end else begin
			async_q <= async_wrap ? 7'h00 : async_q + 7'h01;
			if (async_wrap) begin
				sync_q <= sync_wrap ? 13'h0000 : sync_q + 13'h0001;
			end
			tick_q <= async_wrap && sync_wrap;
		end
	end

	assign tk.sec_tick = tick_q;
endmodule

// file: rpsc_core_properties.sv
`timescale 1ns/1ps
`include "rpsc_cfg.svh"
module rpsc_core_properties
	import rpsc_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire logic        key_wr,
	input wire logic [7:0]  key_data,
	input wire logic        psc_wr,
	input wire logic        rsf_clr,
	input wire logic        deinit,
	input wire logic        shadow_synced_flag,
	input wire logic        init_active,
	input wire logic        wr_unlocked,
	input wire logic [6:0]  psc_async_out,
	input wire logic [12:0] psc_sync_out,
	input wire rpsc_flags_t ien_out,
	input wire rpsc_flags_t evt_flags,
	input wire logic        alarm_irq_line17,
	input wire logic        wakeup_irq_channel,
	input wire logic        tamper_stamp_irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_l17;
		alarm_irq_line17 == $past(|(evt_flags[1:0] & ien_out[1:0]));
	endproperty
	a_l17: assert property (p_l17) else $error("line 17 wrong");
	property p_l22;
		wakeup_irq_channel == $past(evt_flags[2] & ien_out[2]);
	endproperty
	a_l22: assert property (p_l22) else $error("line 22 wrong");
	property p_l21;
		tamper_stamp_irq == $past(|(evt_flags[4:3] & ien_out[4:3]));
	endproperty
	a_l21: assert property (p_l21) else $error("line 21 wrong");
	property p_unlock;
		$past(key_wr && key_data == `RPSC_KEY_FIRST && !wr_unlocked)
			&& key_wr && key_data == `RPSC_KEY_SECOND |=> wr_unlocked;
	endproperty
	a_unlock: assert property (p_unlock) else $error("key did not unlock");
	property p_relock;
		key_wr && key_data != `RPSC_KEY_SECOND |=> !wr_unlocked;
	endproperty
	a_relock: assert property (p_relock) else $error("wrong key kept unlock");
	property p_psc;
		psc_wr && !(wr_unlocked && init_active) && !deinit
			|=> $stable(psc_async_out) && $stable(psc_sync_out);
	endproperty
	a_psc: assert property (p_psc) else $error("prescaler write leaked");
	property p_rsf;
		rsf_clr && !wr_unlocked && shadow_synced_flag |=> shadow_synced_flag;
	endproperty
	a_rsf: assert property (p_rsf) else $error("locked flag clear taken");
	property p_restart;
		$fell(init_active) && !$past(deinit)
			|-> !shadow_synced_flag [*4] ##[1:4] shadow_synced_flag;
	endproperty
	a_restart: assert property (p_restart) else $error("restart timing wrong");
	c_unlock: cover property (!wr_unlocked ##1 wr_unlocked);
	c_irq: cover property ($rose(alarm_irq_line17));
	c_exit: cover property ($fell(init_active));
endmodule
bind rpsc_core rpsc_core_properties u_props (.*);

// file: rpsc_router_model.sv
`timescale 1ns/1ps
module rpsc_router_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic [2:0] armed,
	input  wire logic [2:0] line_in,
	output logic [2:0][7:0] hits
);
	logic [2:0] last_q;
	// Only armed lines count rising edges, so an edge that comes before its line is armed is lost.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			last_q <= 3'h0;
			hits <= '0;
		end else begin
			last_q <= line_in;
			for (int i = 0; i < 3; i++) begin
				if (armed[i] && line_in[i] && !last_q[i]) begin
					hits[i] <= hits[i] + 8'h01;
				end
			end
		end
	end
endmodule

// file: rpsc_core_bench.sv
`timescale 1ns/1ps
`include "rpsc_cfg.svh"
module rpsc_core_bench
	import rpsc_pkg::*;
;
	logic ref_clk = 1'b0, rst_b = 1'b0, sys_rst_b = 1'b1;
	logic key_wr, init_wr, init_val, psc_wr, cal_wr, rsf_clr, refclk_wr, refclk_val;
	logic clksrc_wr, ien_wr, deinit, tamp_cfg_wr, bkp_wr;
	logic [7:0]  key_data, tamp_cfg_val, tamper_altfunc_cfg;
	logic [6:0]  psc_async, psc_async_out;
	logic [12:0] psc_sync, psc_sync_out;
	logic [1:0]  clksrc_val, kernel_clock_sel;
	logic [4:0]  bkp_wr_idx, bkp_rd_idx;
	rpsc_word_t  cal_time, cal_date, bkp_wdata, bkp_rdata, time_shadow_reg, date_shadow_reg;
	rpsc_flags_t ien_val, evt_in, flag_clr, ien_out, evt_flags;
	logic shadow_synced_flag, init_active, wr_unlocked, refclk_det_en;
	logic alarm_irq_line17, wakeup_irq_channel, tamper_stamp_irq;
	logic [2:0]  armed;
	logic [2:0][7:0] hits;
	int err_count = 0, n_compared = 0, cyc = 0;
	int ix [3] = '{0, 19, 20};
	logic [2:0] irq_map [5] = '{3'h1, 3'h1, 3'h4, 3'h2, 3'h2};

	rpsc_core u_dut (.*);
	rpsc_router_model u_rtr (.ref_clk, .rst_b, .armed, .hits,
		.line_in({wakeup_irq_channel, tamper_stamp_irq, alarm_irq_line17}));

	always #20 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			wrap_up;
		end
	end

	// ***************************************
	// Access tasks.
	// ***************************************
	task automatic step(int n = 1);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic idle;
		{key_wr, init_wr, psc_wr, cal_wr, rsf_clr, refclk_wr, clksrc_wr} = '0;
		{ien_wr, deinit, tamp_cfg_wr, bkp_wr, evt_in, flag_clr} = '0;
	endtask
	// One idle edge follows every pulse, so no strobe is cleared and set in one step.
	task automatic go;
		step;
		idle;
		step;
	endtask
	task automatic chk(logic [63:0] got, logic [63:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic unlock;
		key_wr = 1'b1;
		key_data = `RPSC_KEY_FIRST;
		step;
		key_data = `RPSC_KEY_SECOND;
		go;
	endtask
	task automatic sync;
		for (int i = 0; i < 20 && shadow_synced_flag !== 1'b1; i++) step;
	endtask
	task automatic wrap_up;
		$display("compared %0d, mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		idle;
		{init_val, refclk_val, key_data, tamp_cfg_val, clksrc_val, armed} = '0;
		{psc_async, psc_sync, cal_time, cal_date, bkp_wdata, ien_val} = '0;
		{bkp_wr_idx, bkp_rd_idx} = '0;
		step(2);
		rst_b = 1'b1;
		step(3);
		chk(wr_unlocked, 0);
		chk({psc_async_out, psc_sync_out}, {`RPSC_ASYNC_RST, `RPSC_SYNC_RST});
		ien_wr = 1'b1;
		ien_val = 5'h1F;
		go;
		chk(ien_out, 0);
		tamp_cfg_wr = 1'b1;
		tamp_cfg_val = 8'h3C;
		go;
		chk(tamper_altfunc_cfg, 8'h3C);
		foreach (ix[i]) begin
			bkp_wr = 1'b1;
			bkp_wr_idx = ix[i][4:0];
			bkp_wdata = 32'hB0D0_0000 + ix[i];
			go;
			bkp_rd_idx = ix[i][4:0];
			step;
			chk(bkp_rdata, ix[i] < 20 ? 32'hB0D0_0000 + ix[i] : 32'h0);
		end
		unlock;
		chk(wr_unlocked, 1);
		sys_rst_b = 1'b0;
		step(4);
		sys_rst_b = 1'b1;
		step(3);
		chk(wr_unlocked, 1);
		psc_wr = 1'b1;
		psc_async = 7'h03;
		psc_sync = 13'h0003;
		go;
		chk(psc_async_out, `RPSC_ASYNC_RST);
		init_wr = 1'b1;
		init_val = 1'b1;
		go;
		chk(init_active, 1);
		psc_wr = 1'b1;
		cal_wr = 1'b1;
		cal_time = `RPSC_DAY_LAST;
		cal_date = 32'h5;
		go;
		chk({psc_async_out, psc_sync_out}, {7'h03, 13'h0003});
		init_wr = 1'b1;
		init_val = 1'b0;
		go;
		sync;
		chk({time_shadow_reg, date_shadow_reg}, {`RPSC_DAY_LAST, 32'h5});
		step(20);
		rsf_clr = 1'b1;
		step;
		chk(shadow_synced_flag, 0);
		rsf_clr = 1'b0;
		sync;
		chk({time_shadow_reg, date_shadow_reg}, {32'h0, 32'h6});
		key_wr = 1'b1;
		key_data = 8'h00;
		go;
		chk(wr_unlocked, 0);
		rsf_clr = 1'b1;
		step;
		chk(shadow_synced_flag, 1);
		rsf_clr = 1'b0;
		step;
		unlock;
		armed = 3'h7;
		ien_wr = 1'b1;
		ien_val = 5'h1F;
		go;
		for (int i = 0; i < 5; i++) begin
			evt_in = 5'h01 << i;
			go;
			step;
			chk({wakeup_irq_channel, tamper_stamp_irq, alarm_irq_line17}, irq_map[i]);
			flag_clr = 5'h01 << i;
			go;
			step;
			chk({wakeup_irq_channel, tamper_stamp_irq, alarm_irq_line17}, 3'h0);
		end
		chk(hits, 24'h010202);
		ien_wr = 1'b1;
		ien_val = 5'h00;
		go;
		evt_in = 5'h01;
		go;
		step;
		chk({evt_flags[0], alarm_irq_line17}, 2'h2);
		refclk_wr = 1'b1;
		refclk_val = 1'b1;
		clksrc_wr = 1'b1;
		clksrc_val = 2'h2;
		go;
		chk({refclk_det_en, kernel_clock_sel}, 3'h6);
		deinit = 1'b1;
		go;
		bkp_rd_idx = 5'h13;
		step;
		chk({refclk_det_en, kernel_clock_sel, evt_flags}, {3'h2, 5'h0});
		chk(bkp_rdata, 32'hB0D0_0013);
		wrap_up;
	end
endmodule
